//--- src/adc_setup_register_bank.sv
// Setup register bank of a multiplexed converter, reached over a mode-3 serial port.
// Assumes serial pins are already synchronous to clk and sclk is much slower than clk.
`timescale 1ns/1ns
`default_nettype none
module adc_setup_register_bank
  import adc_regs_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        spi_sclk,
  input  wire logic        spi_cs_n,
  input  wire logic        spi_din,
  output logic             spi_dout_ff,
  output logic             spi_dout_oe_ff,
  input  wire logic [23:0] gain_trim,
  input  wire logic        conv_done,
  input  wire logic        cal_offset_valid,
  input  wire logic        cal_gain_valid,
  input  wire logic [1:0]  cal_setup,
  input  wire logic [23:0] cal_value,
  input  wire logic        raw_valid,
  input  wire logic [23:0] raw_result,
  output chan_sel_s        active_chan_ff,
  output setup_view_s      active_setup_ff,
  output logic      [15:0] mode_word_ff,
  output logic      [15:0] iface_word_ff,
  output logic      [23:0] result_ff,
  output logic             result_valid_ff
);

  // Serial engine state
  spi_state_e  state_ff;
  spi_state_e  nxt_state;
  logic        sclk_prev_ff;
  logic [4:0]  bit_cnt_ff;
  logic [4:0]  nxt_bit_cnt;
  logic [4:0]  len_ff;
  logic [4:0]  nxt_len;
  logic [5:0]  addr_ff;
  logic [5:0]  nxt_addr;
  logic [23:0] shreg_ff;
  logic [23:0] nxt_shreg;
  logic        nxt_dout;
  logic        nxt_dout_oe;
  logic [6:0]  ones_ff;
  logic [6:0]  nxt_ones;
  logic        soft_rst_ff;
  logic        nxt_soft_rst;
  logic        rise;
  logic        fall;
  logic        rst_all;
  logic [7:0]  cmd_byte;

  // Host write strobe
  logic        host_wr;
  logic [23:0] host_wr_data;

  // Registers outside the store
  logic [15:0] chan_ff [NUM_CH];
  logic [15:0] nxt_chan [NUM_CH];
  logic [15:0] nxt_mode;
  logic [15:0] nxt_iface;

  // Store ports
  logic        mem_wr_en;
  logic [3:0]  mem_wr_addr;
  logic [23:0] mem_wr_data;
  logic [3:0]  mem_rd_addr;
  logic [23:0] mem_rd_data;
  setup_view_s view;

  // Sequencer and result
  chan_sel_s   nxt_active;
  logic [1:0]  cur_ch;
  logic [23:0] nxt_result;
  logic        nxt_result_valid;

  function automatic logic is_store(input logic [5:0] a);
    logic hit;
    hit = 1'b0;
    if ((a & ADDR_BANK_MASK) == ADDR_SETUP)
    begin
      hit = 1'b1;
    end
    else if ((a & ADDR_BANK_MASK) == ADDR_FILT)
    begin
      hit = 1'b1;
    end
    else if ((a & ADDR_BANK_MASK) == ADDR_OFFS)
    begin
      hit = 1'b1;
    end
    else if ((a & ADDR_BANK_MASK) == ADDR_GAIN)
    begin
      hit = 1'b1;
    end
    return hit;
  endfunction

  function automatic logic [3:0] store_index(input logic [5:0] a);
    return {a[4:3], a[1:0]};
  endfunction

  function automatic logic [4:0] reg_len(input logic [5:0] a);
    logic [4:0] n;
    n = LEN_SHORT;
    if ((a & ADDR_BANK_MASK) == ADDR_OFFS)
    begin
      n = LEN_LONG;
    end
    else if ((a & ADDR_BANK_MASK) == ADDR_GAIN)
    begin
      n = LEN_LONG;
    end
    return n;
  endfunction

  // Writable bits of a store word by kind
  function automatic logic [23:0] store_mask(input logic [5:0] a);
    logic [23:0] m;
    m = 24'hffffff;
    if ((a & ADDR_BANK_MASK) == ADDR_SETUP)
    begin
      m = {8'h00, SETUP_MASK};
    end
    else if ((a & ADDR_BANK_MASK) == ADDR_FILT)
    begin
      m = {8'h00, FILT_MASK};
    end
    return m;
  endfunction

  function automatic logic [1:0] next_channel(input logic [1:0] cur, input logic [3:0] en);
    logic [1:0] pick;
    logic       found;
    logic [1:0] cand;
    pick  = cur;
    found = 1'b0;
    for (int k = 1; k <= NUM_CH; k++)
    begin
      cand = 2'(cur + 2'(k));
      if (!found && en[cand])
      begin
        pick  = cand;
        found = 1'b1;
      end
    end
    return pick;
  endfunction

  assign rst_all  = rst | soft_rst_ff;
  assign rise     = !spi_cs_n && spi_sclk && !sclk_prev_ff;
  assign fall     = !spi_cs_n && !spi_sclk && sclk_prev_ff;
  assign cmd_byte = {shreg_ff[6:0], spi_din};

  // Serial engine: command byte, then data of the addressed register's length
  always_comb
  begin
    nxt_state    = state_ff;
    nxt_bit_cnt  = bit_cnt_ff;
    nxt_len      = len_ff;
    nxt_addr     = addr_ff;
    nxt_shreg    = shreg_ff;
    nxt_dout     = spi_dout_ff;
    nxt_dout_oe  = spi_dout_oe_ff;
    nxt_ones     = ones_ff;
    nxt_soft_rst = 1'b0;
    host_wr      = 1'b0;
    host_wr_data = {shreg_ff[22:0], spi_din};
    if (spi_cs_n)
    begin
      nxt_state   = SPI_CMD;
      nxt_bit_cnt = 5'h00;
      nxt_dout_oe = 1'b0;
      nxt_ones    = 7'h00;
    end
    else
    begin
      if (rise)
      begin
        nxt_ones = spi_din ? ones_ff + 7'h01 : 7'h00;
        if (spi_din && (ones_ff == RESET_ONES - 7'h01))
        begin
          nxt_soft_rst = 1'b1;
        end
      end
      case (state_ff)
        SPI_CMD:
        begin
          if (rise)
          begin
            nxt_shreg   = {shreg_ff[22:0], spi_din};
            nxt_bit_cnt = bit_cnt_ff + 5'h01;
            if (bit_cnt_ff == CMD_BITS - 5'h01)
            begin
              nxt_bit_cnt = 5'h00;
              if (!cmd_byte[CMD_WEN_BIT])
              begin
                nxt_addr  = cmd_byte[5:0];
                nxt_len   = reg_len(cmd_byte[5:0]);
                nxt_state = cmd_byte[CMD_RD_BIT] ? SPI_LOAD : SPI_WRITE;
              end
            end
          end
        end
        SPI_LOAD:
        begin
          nxt_shreg = 24'h000000;
          if (is_store(addr_ff))
          begin
            nxt_shreg = mem_rd_data;
          end
          else if (addr_ff == ADDR_MODE)
          begin
            nxt_shreg = {8'h00, mode_word_ff};
          end
          else if (addr_ff == ADDR_IFACE)
          begin
            nxt_shreg = {8'h00, iface_word_ff};
          end
          else if (addr_ff == ADDR_IDENT)
          begin
            nxt_shreg = {8'h00, IDENT_VALUE};
          end
          else if ((addr_ff & ADDR_BANK_MASK) == ADDR_CHAN)
          begin
            nxt_shreg = {8'h00, chan_ff[addr_ff[1:0]]};
          end
          if (len_ff == LEN_SHORT)
          begin
            nxt_shreg = {nxt_shreg[15:0], 8'h00};
          end
          nxt_dout    = nxt_shreg[23];
          nxt_dout_oe = 1'b1;
          nxt_state   = SPI_READ;
        end
        SPI_READ:
        begin
          if (fall)
          begin
            nxt_shreg = {shreg_ff[22:0], 1'b0};
            nxt_dout  = shreg_ff[23];
          end
          if (rise)
          begin
            nxt_bit_cnt = bit_cnt_ff + 5'h01;
            if (bit_cnt_ff == len_ff - 5'h01)
            begin
              nxt_bit_cnt = 5'h00;
              nxt_dout_oe = 1'b0;
              nxt_state   = SPI_CMD;
            end
          end
        end
        default:
        begin
          if (rise)
          begin
            nxt_shreg   = {shreg_ff[22:0], spi_din};
            nxt_bit_cnt = bit_cnt_ff + 5'h01;
            if (bit_cnt_ff == len_ff - 5'h01)
            begin
              nxt_bit_cnt = 5'h00;
              host_wr     = 1'b1;
              nxt_state   = SPI_CMD;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst_all)
    begin
      state_ff       <= SPI_CMD;
      sclk_prev_ff   <= 1'b1;
      bit_cnt_ff     <= 5'h00;
      len_ff         <= LEN_SHORT;
      addr_ff        <= 6'h00;
      shreg_ff       <= 24'h000000;
      spi_dout_ff    <= 1'b1;
      spi_dout_oe_ff <= 1'b0;
      ones_ff        <= 7'h00;
    end
    else
    begin
      state_ff       <= nxt_state;
      sclk_prev_ff   <= spi_sclk;
      bit_cnt_ff     <= nxt_bit_cnt;
      len_ff         <= nxt_len;
      addr_ff        <= nxt_addr;
      shreg_ff       <= nxt_shreg;
      spi_dout_ff    <= nxt_dout;
      spi_dout_oe_ff <= nxt_dout_oe;
      ones_ff        <= nxt_ones;
    end
  end

  // The soft reset pulse must outlive the reset it causes, so only rst clears it
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      soft_rst_ff <= 1'b0;
    end
    else
    begin
      soft_rst_ff <= nxt_soft_rst;
    end
  end

  // Host writes to mode, interface and channel words
  always_comb
  begin
    nxt_mode  = mode_word_ff;
    nxt_iface = iface_word_ff;
    for (int i = 0; i < NUM_CH; i++)
    begin
      nxt_chan[i] = chan_ff[i];
    end
    if (host_wr)
    begin
      if (addr_ff == ADDR_MODE)
      begin
        nxt_mode = host_wr_data[15:0] & MODE_MASK;
      end
      else if (addr_ff == ADDR_IFACE)
      begin
        nxt_iface = host_wr_data[15:0] & IFACE_MASK;
      end
      else if ((addr_ff & ADDR_BANK_MASK) == ADDR_CHAN)
      begin
        nxt_chan[addr_ff[1:0]] = host_wr_data[15:0] & CHAN_MASK;
      end
      // identity and unmapped writes fall through unchanged
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst_all)
    begin
      mode_word_ff  <= MODE_RST;
      iface_word_ff <= IFACE_RST;
      chan_ff[0]    <= CHAN0_RST;
      for (int i = 1; i < NUM_CH; i++)
      begin
        chan_ff[i] <= CHANX_RST;
      end
    end
    else
    begin
      mode_word_ff  <= nxt_mode;
      iface_word_ff <= nxt_iface;
      for (int i = 0; i < NUM_CH; i++)
      begin
        chan_ff[i] <= nxt_chan[i];
      end
    end
  end

  // Store writes; a finishing calibration wins over a host write in the same cycle
  always_comb
  begin
    mem_wr_en   = 1'b0;
    mem_wr_addr = store_index(addr_ff);
    mem_wr_data = host_wr_data & store_mask(addr_ff);
    mem_rd_addr = store_index(nxt_addr);
    if (cal_offset_valid)
    begin
      mem_wr_en   = 1'b1;
      mem_wr_addr = {KIND_OFFS, cal_setup};
      mem_wr_data = cal_value;
    end
    else if (cal_gain_valid)
    begin
      mem_wr_en   = 1'b1;
      mem_wr_addr = {KIND_GAIN, cal_setup};
      mem_wr_data = cal_value;
    end
    else if (host_wr && is_store(addr_ff))
    begin
      mem_wr_en = 1'b1;
    end
  end

  setup_store u_store (
    .clk        (clk),
    .rst        (rst_all),
    .gain_trim  (gain_trim),
    .wr_en      (mem_wr_en),
    .wr_addr    (mem_wr_addr),
    .wr_data    (mem_wr_data),
    .rd_addr    (mem_rd_addr),
    .rd_data_ff (mem_rd_data),
    .view_setup (active_chan_ff.setup_ptr[1:0]),
    .view_ff    (view)
  );

  // Sequencer and result coding
  always_comb
  begin
    cur_ch = active_chan_ff.channel;
    if (conv_done)
    begin
      cur_ch = next_channel(active_chan_ff.channel,
                            {chan_ff[3][CH_EN_BIT], chan_ff[2][CH_EN_BIT],
                             chan_ff[1][CH_EN_BIT], chan_ff[0][CH_EN_BIT]});
    end
    nxt_active.channel   = cur_ch;
    nxt_active.setup_ptr = chan_ff[cur_ch][CH_SETUP_LSB +: 3];
    nxt_active.pos_pick  = chan_ff[cur_ch][CH_POS_LSB +: 5];
    nxt_active.neg_pick  = chan_ff[cur_ch][CH_NEG_LSB +: 5];
    nxt_active.enabled   = chan_ff[cur_ch][CH_EN_BIT];
    nxt_result           = result_ff;
    nxt_result_valid     = 1'b0;
    if (raw_valid)
    begin
      nxt_result_valid = 1'b1;
      if (view.config_word[SETUP_POLAR_BIT])
      begin
        nxt_result = {~raw_result[23], raw_result[22:0]};
      end
      // straight binary, negatives clamp to zero
      else
      begin
        nxt_result = raw_result[23] ? 24'h000000 : {raw_result[22:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst_all)
    begin
      active_chan_ff  <= '0;
      active_setup_ff <= '0;
      result_ff       <= 24'h000000;
      result_valid_ff <= 1'b0;
    end
    else
    begin
      active_chan_ff  <= nxt_active;
      active_setup_ff <= view;
      result_ff       <= nxt_result;
      result_valid_ff <= nxt_result_valid;
    end
  end

endmodule
`default_nettype wire

//--- src/adc_regs_pkg.sv
// Register map, field layout, reset values and carriers of the converter setup bank.
// Assumes one synchronous clock domain; serial pins are sampled as ordinary inputs.
package adc_regs_pkg;

  // Register addresses carried in the six-bit pointer of the command byte
  localparam logic [5:0]  ADDR_MODE      = 6'h01;
  localparam logic [5:0]  ADDR_IFACE     = 6'h02;
  localparam logic [5:0]  ADDR_IDENT     = 6'h07;
  localparam logic [5:0]  ADDR_CHAN      = 6'h10;
  localparam logic [5:0]  ADDR_SETUP     = 6'h20;
  localparam logic [5:0]  ADDR_FILT      = 6'h28;
  localparam logic [5:0]  ADDR_OFFS      = 6'h30;
  localparam logic [5:0]  ADDR_GAIN      = 6'h38;
  localparam logic [5:0]  ADDR_BANK_MASK = 6'h3c;

  // Command byte fields
  localparam int          CMD_WEN_BIT    = 7;
  localparam int          CMD_RD_BIT     = 6;

  // Channel word fields
  localparam int          CH_EN_BIT      = 15;
  localparam int          CH_SETUP_LSB   = 12;
  localparam int          CH_POS_LSB     = 5;
  localparam int          CH_NEG_LSB     = 0;

  // Setup word fields
  localparam int          SETUP_POLAR_BIT = 12;

  // Writable-bit masks; reserved positions stay zero
  localparam logic [15:0] MODE_MASK      = 16'he77c;
  localparam logic [15:0] IFACE_MASK     = 16'h19ea;
  localparam logic [15:0] CHAN_MASK      = 16'hf3ff;
  localparam logic [15:0] SETUP_MASK     = 16'h1fb0;
  localparam logic [15:0] FILT_MASK      = 16'h8f7f;

  // Reset values
  localparam logic [15:0] MODE_RST       = 16'h8000;
  localparam logic [15:0] IFACE_RST      = 16'h0000;
  localparam logic [15:0] CHAN0_RST      = 16'h8001;
  localparam logic [15:0] CHANX_RST      = 16'h0001;
  localparam logic [15:0] SETUP_RST      = 16'h1320;
  localparam logic [15:0] FILT_RST       = 16'h0000;
  localparam logic [23:0] OFFS_RST       = 24'h800000;
  // Identity value is arbitrary
  localparam logic [15:0] IDENT_VALUE    = 16'h3c5a;

  // Store kinds, taken from address bits [4:3]
  localparam logic [1:0]  KIND_SETUP     = 2'h0;
  localparam logic [1:0]  KIND_FILT      = 2'h1;
  localparam logic [1:0]  KIND_OFFS      = 2'h2;
  localparam logic [1:0]  KIND_GAIN      = 2'h3;

  localparam int          NUM_CH         = 4;
  localparam int          NUM_SETUP      = 4;
  localparam logic [4:0]  LEN_SHORT      = 5'h10;
  localparam logic [4:0]  LEN_LONG       = 5'h18;
  localparam logic [4:0]  CMD_BITS       = 5'h08;
  // Consecutive high input bits that restart the whole device
  localparam logic [6:0]  RESET_ONES     = 7'h40;

  typedef enum logic [1:0] {
    SPI_CMD   = 2'b00,
    SPI_LOAD  = 2'b01,
    SPI_READ  = 2'b10,
    SPI_WRITE = 2'b11
  } spi_state_e;

  typedef struct packed {
    logic [15:0] config_word;
    logic [15:0] filter_word;
    logic [23:0] offset_word;
    logic [23:0] gain_word;
  } setup_view_s;

  typedef struct packed {
    logic [1:0] channel;
    logic [2:0] setup_ptr;
    logic [4:0] pos_pick;
    logic [4:0] neg_pick;
    logic       enabled;
  } chan_sel_s;

endpackage

//--- src/setup_store.sv
// Sixteen-word store for the four setups: configuration, filter, offset and gain.
// Assumes one writer per cycle; read data and the setup view come from registers.
`timescale 1ns/1ns
`default_nettype none
module setup_store
  import adc_regs_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [23:0] gain_trim,
  input  wire logic        wr_en,
  input  wire logic [3:0]  wr_addr,
  input  wire logic [23:0] wr_data,
  input  wire logic [3:0]  rd_addr,
  output logic      [23:0] rd_data_ff,
  input  wire logic [1:0]  view_setup,
  output setup_view_s      view_ff
);

  logic [23:0] mem_ff [16];
  logic [23:0] nxt_mem [16];
  logic [23:0] nxt_rd_data;
  setup_view_s nxt_view;

  function automatic logic [23:0] reset_word(input logic [1:0] kind, input logic [23:0] trim);
    logic [23:0] w;
    w = {8'h00, FILT_RST};
    if (kind == KIND_SETUP)
    begin
      w = {8'h00, SETUP_RST};
    end
    else if (kind == KIND_OFFS)
    begin
      w = OFFS_RST;
    end
    else if (kind == KIND_GAIN)
    begin
      w = trim;
    end
    return w;
  endfunction

  always_comb
  begin
    for (int i = 0; i < 16; i++)
    begin
      nxt_mem[i] = mem_ff[i];
    end
    if (wr_en)
    begin
      nxt_mem[wr_addr] = wr_data;
    end
    nxt_rd_data          = mem_ff[rd_addr];
    nxt_view.config_word = mem_ff[{KIND_SETUP, view_setup}][15:0];
    nxt_view.filter_word = mem_ff[{KIND_FILT, view_setup}][15:0];
    nxt_view.offset_word = mem_ff[{KIND_OFFS, view_setup}];
    nxt_view.gain_word   = mem_ff[{KIND_GAIN, view_setup}];
  end

  // Gain words take the factory trim while reset is held
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < 16; i++)
      begin
        mem_ff[i] <= reset_word(2'(i >> 2), gain_trim);
      end
      rd_data_ff <= 24'h000000;
      view_ff    <= '0;
    end
    else
    begin
      for (int i = 0; i < 16; i++)
      begin
        mem_ff[i] <= nxt_mem[i];
      end
      rd_data_ff <= nxt_rd_data;
      view_ff    <= nxt_view;
    end
  end

endmodule
`default_nettype wire

//--- testbench/adc_bank_props.sv
// Checker of the setup register bank, watching only its top-level ports.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ns
`default_nettype none
module adc_bank_props
  import adc_regs_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        spi_cs_n,
  input wire logic        conv_done,
  input wire logic        raw_valid,
  input wire logic [23:0] raw_result,
  input wire chan_sel_s   active_chan_ff,
  input wire setup_view_s active_setup_ff,
  input wire logic [15:0] mode_word_ff,
  input wire logic [15:0] iface_word_ff,
  input wire logic [23:0] result_ff,
  input wire logic        result_valid_ff
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  reset_word_a:
    assert property ($fell(rst) |-> mode_word_ff == MODE_RST && iface_word_ff == IFACE_RST)
      else $error("mode words wrong after reset");
  result_pulse_a:
    assert property (raw_valid |=> result_valid_ff)
      else $error("result strobe missing");
  result_once_a:
    assert property (!raw_valid |=> !result_valid_ff && $stable(result_ff))
      else $error("result moved without raw data");
  bipolar_code_a:
    assert property (raw_valid && active_setup_ff.config_word[SETUP_POLAR_BIT] |=>
      result_ff == {~$past(raw_result[23]), $past(raw_result[22:0])})
      else $error("offset binary coding wrong");
  unipolar_code_a:
    assert property (raw_valid && !active_setup_ff.config_word[SETUP_POLAR_BIT] |=>
      result_ff == ($past(raw_result[23]) ? 24'h0 : {$past(raw_result[22:0]), 1'h0}))
      else $error("straight binary coding wrong");
  skip_disabled_a:
    assert property (conv_done |=> active_chan_ff.enabled)
      else $error("sequencer landed on disabled channel");
  mode_quiet_a:
    assert property ($changed(mode_word_ff) || $changed(iface_word_ff) |-> !$past(spi_cs_n))
      else $error("mode word changed while deselected");
  seq_order_a:
    assert property (!conv_done |=> $stable(active_chan_ff.channel))
      else $error("channel moved without conversion end");
endmodule

bind adc_setup_register_bank adc_bank_props adc_bank_props_i (.clk, .rst, .spi_cs_n,
  .conv_done, .raw_valid, .raw_result, .active_chan_ff, .active_setup_ff, .mode_word_ff,
  .iface_word_ff, .result_ff, .result_valid_ff);
`default_nettype wire

//--- testbench/spi_host_model.sv
// Mode-3 serial host that reaches the register bank through command bytes.
// Assumes clk runs the bank; each serial half period lasts five clk cycles.
`timescale 1ns/1ns
`default_nettype none
module spi_host_model
(
  input  wire logic clk,
  output var logic  sclk,
  output var logic  cs_n,
  output var logic  din,
  input  wire logic dout,
  input  wire logic dout_oe
);
  initial
  begin
    sclk = 1'h1;
    cs_n = 1'h1;
    din  = 1'h1;
  end

  task automatic hold();
    repeat (5) @(posedge clk);
    #1;
  endtask

  // Released data line reads as the inverse, never as a stale bit
  task automatic shift(input logic b, output logic r);
    sclk = 1'h0;
    din  = b;
    hold();
    r = dout_oe ? dout : ~dout;
    sclk = 1'h1;
    hold();
  endtask

  task automatic xfer(input logic [7:0] cmd, input logic [23:0] wd, output logic [23:0] rd);
    logic r;
    int   n;
    n  = (cmd[5:4] == 2'h3 && !cmd[2]) ? 24 : 16;
    rd = 24'h0;
    cs_n = 1'h0;
    hold();
    for (int i = 7; i >= 0; i--)
      shift(cmd[i], r);
    for (int i = n - 1; i >= 0; i--)
    begin
      shift(wd[i], r);
      rd[i] = r;
    end
    cs_n = 1'h1;
    hold();
  endtask

  // A long run of high bits with select low restarts the whole bank
  task automatic ones(input int n);
    logic r;
    cs_n = 1'h0;
    hold();
    for (int i = 0; i < n; i++)
      shift(1'h1, r);
    cs_n = 1'h1;
    hold();
  endtask
endmodule
`default_nettype wire

//--- testbench/testbench.sv
// Self-checking bench of the setup register bank.
// Assumes the host model drives the serial port; clock period 40 ns.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import adc_regs_pkg::*;
  // Stands in for the factory trim
  localparam logic [23:0] TRIM = 24'h5a5a50;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic spi_sclk, spi_cs_n, spi_din, spi_dout_ff, spi_dout_oe_ff, result_valid_ff;
  logic conv_done = 1'h0, cal_offset_valid = 1'h0, cal_gain_valid = 1'h0, raw_valid = 1'h0;
  logic [1:0] cal_setup = 2'h0;
  logic [23:0] cal_value = 24'h0, raw_result = 24'h0, gain_trim = TRIM, result_ff;
  logic [15:0] mode_word_ff, iface_word_ff;
  chan_sel_s active_chan_ff;
  setup_view_s active_setup_ff;
  int fails = 0;
  int samples_checked = 0;

  adc_setup_register_bank adc_setup_register_bank_i (.clk, .rst, .spi_sclk, .spi_cs_n,
    .spi_din, .spi_dout_ff, .spi_dout_oe_ff, .gain_trim, .conv_done, .cal_offset_valid,
    .cal_gain_valid, .cal_setup, .cal_value, .raw_valid, .raw_result, .active_chan_ff,
    .active_setup_ff, .mode_word_ff, .iface_word_ff, .result_ff, .result_valid_ff);
  spi_host_model spi_host_model_i (.clk, .sclk(spi_sclk), .cs_n(spi_cs_n), .din(spi_din),
    .dout(spi_dout_ff), .dout_oe(spi_dout_oe_ff));

  initial
    forever #20 clk = ~clk;

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [5:0] a, input logic [23:0] exp);
    logic [23:0] v;
    spi_host_model_i.xfer({2'h1, a}, 24'h0, v);
    check(v, exp);
  endtask
  task automatic wr(input logic [5:0] a, input logic [23:0] d);
    logic [23:0] v;
    spi_host_model_i.xfer({2'h0, a}, d, v);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic step(input logic [1:0] ch);
    conv_done = 1'h1;
    tick(1);
    conv_done = 1'h0;
    tick(3);
    check(active_chan_ff.channel, ch);
  endtask
  task automatic conv(input logic [23:0] raw, input logic [23:0] exp);
    raw_valid  = 1'h1;
    raw_result = raw;
    tick(1);
    raw_valid = 1'h0;
    check(result_valid_ff, 24'h1);
    tick(2);
    check(result_ff, exp);
  endtask

  task automatic test_reset();
    rd(ADDR_MODE, MODE_RST);
    rd(ADDR_IFACE, IFACE_RST);
    rd(ADDR_CHAN, CHAN0_RST);
    rd(ADDR_CHAN + 6'h1, CHANX_RST);
    rd(ADDR_SETUP + 6'h3, SETUP_RST);
    rd(ADDR_FILT, FILT_RST);
    rd(ADDR_OFFS + 6'h2, OFFS_RST);
    rd(ADDR_GAIN + 6'h1, TRIM);
    rd(ADDR_IDENT, IDENT_VALUE);
    $display("reset test done");
  endtask

  task automatic test_regs();
    wr(ADDR_MODE, 24'hffff);
    rd(ADDR_MODE, MODE_MASK);
    check(mode_word_ff, MODE_MASK);
    wr(ADDR_IFACE, 24'hffff);
    rd(ADDR_IFACE, IFACE_MASK);
    check(iface_word_ff, IFACE_MASK);
    wr(ADDR_IFACE, 24'h0);
    wr(ADDR_SETUP + 6'h2, 24'hffff);
    rd(ADDR_SETUP + 6'h2, SETUP_MASK);
    wr(ADDR_FILT + 6'h1, 24'hffff);
    rd(ADDR_FILT + 6'h1, FILT_MASK);
    wr(ADDR_OFFS + 6'h3, 24'h123456);
    rd(ADDR_OFFS + 6'h3, 24'h123456);
    wr(ADDR_GAIN + 6'h2, 24'habcdef);
    rd(ADDR_GAIN + 6'h2, 24'habcdef);
    wr(ADDR_IDENT, 24'hffff);
    rd(ADDR_IDENT, IDENT_VALUE);
    rd(6'h3f, 24'h0);
    $display("register test done");
  endtask

  task automatic test_seq();
    wr(ADDR_SETUP + 6'h1, 24'h0320);
    wr(ADDR_CHAN + 6'h2, 24'h9043);
    wr(ADDR_CHAN + 6'h3, 24'h9084);
    step(2'h2);
    check(active_chan_ff.setup_ptr, 24'h1);
    check(active_chan_ff.pos_pick, 24'h2);
    check(active_chan_ff.neg_pick, 24'h3);
    check(active_setup_ff.config_word, 24'h0320);
    check(active_setup_ff.filter_word, FILT_MASK);
    check(active_setup_ff.offset_word, OFFS_RST);
    check(active_setup_ff.gain_word, TRIM);
    step(2'h3);
    check(active_setup_ff.config_word, 24'h0320);
    conv(24'hfffff0, 24'h0);
    conv(24'h000010, 24'h000020);
    step(2'h0);
    conv(24'h000001, 24'h800001);
    $display("sequencer test done");
  endtask

  task automatic test_cal();
    cal_setup = 2'h2;
    cal_value = 24'h0a0b0c;
    cal_offset_valid = 1'h1;
    tick(1);
    cal_offset_valid = 1'h0;
    rd(ADDR_OFFS + 6'h2, 24'h0a0b0c);
    cal_setup = 2'h3;
    cal_value = 24'h445566;
    cal_gain_valid = 1'h1;
    tick(1);
    cal_gain_valid = 1'h0;
    rd(ADDR_GAIN + 6'h3, 24'h445566);
    $display("calibration test done");
  endtask

  // Result is cleared first so the restart leaves it unchanged
  task automatic test_soft();
    conv(24'h800000, 24'h0);
    spi_host_model_i.ones(64);
    rd(ADDR_MODE, MODE_RST);
    rd(ADDR_CHAN + 6'h2, CHANX_RST);
    rd(ADDR_OFFS + 6'h2, OFFS_RST);
    rd(ADDR_GAIN + 6'h3, TRIM);
    $display("soft reset test done");
  endtask

  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Bounded run; a hang counts as a mismatch
  initial
  begin
    repeat (100000) @(posedge clk);
    fails++;
    end_sim();
  end

  initial
  begin
    tick(8);
    rst = 1'h0;
    test_reset();
    test_regs();
    test_seq();
    test_cal();
    test_soft();
    end_sim();
  end
endmodule
`default_nettype wire
